/* File: logic/twe_target.sv */
// Two-wire serial EEPROM target: pin sampling, protocol engine, array and commit
`timescale 1ns/100ps
module twe_target import twe_pkg::*; #(
  parameter int WR_CYCLES   = WRITE_CYCLES,
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               sample_clk,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic [STRAP_W-1:0] device_select_straps,
  input  wire logic               write_protect,
  output logic                    write_busy
);
  localparam int GLITCH_CYCLES = ns_to_link_cycles(LOW_VOLTAGE ? GLITCH_LV_NS : GLITCH_HV_NS);
  localparam logic [GLITCH_CNT_W-1:0] GLITCH_LAST = GLITCH_CNT_W'(GLITCH_CYCLES - 1);
  localparam int PIN_W = STRAP_W + 3;
  // Bus lines idle high; straps and protect idle low like the pull-downs
  localparam logic [PIN_W-1:0] PIN_RST = PIN_W'(3);

  twe_wr_if wr_bus ();

  logic                    link_rst;
  logic [PIN_W-1:0]        pin_q;
  logic [1:0]              line_filt;
  logic [1:0]              line_prev;
  logic [GLITCH_CNT_W-1:0] gl_cnt [2];
  logic                    scl;
  logic                    sda;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_ev;
  logic                    stop_ev;
  logic [STRAP_W-1:0]      straps_q;
  logic                    wp_q;
  logic                    done_q;
  logic                    done_seen;

  twe_state_t              state;
  twe_byte_t               byte_idx;
  logic [3:0]              bit_cnt;
  logic [BYTE_W-1:0]       shreg;
  logic [BYTE_W-1:0]       tx;
  logic                    rd_mode;
  logic                    acked;
  logic [ADDR_W-1:0]       addr;
  logic [PAGE_BYTES-1:0]   wmask;
  logic                    wr_pending;
  logic                    commit_go;
  logic                    committing;
  logic [PAGE_W-1:0]       commit_idx;
  logic                    sel_hit;
  logic [BYTE_W-1:0]       rd_byte;

  logic [BYTE_W-1:0]       mem      [DEPTH];
  logic [BYTE_W-1:0]       page_buf [PAGE_BYTES];

  // Reset reaches the sampling domain through its own synchroniser
  twe_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk (sample_clk),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (link_rst)
  );

  twe_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk (sample_clk),
    .rst (link_rst),
    .d   ({write_protect, device_select_straps, sda_in, scl_in}),
    .q   (pin_q)
  );

  twe_sync #(.W(1), .RST_VAL(1'b0)) u_done_sync (
    .clk (sample_clk),
    .rst (link_rst),
    .d   (wr_bus.done_tgl),
    .q   (done_q)
  );

  twe_wr_timer #(.CYCLES(WR_CYCLES)) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr      (wr_bus.timer)
  );

  // Straps and protect read low when left open: pull-downs sit on the board
  assign straps_q = pin_q[STRAP_W+1:2];
  assign wp_q     = pin_q[PIN_W-1];

  // Glitch filter: a level must hold the suppression time before it counts
  always_ff @(posedge sample_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (link_rst) begin
        gl_cnt[i]    <= '0;
        line_filt[i] <= 1'b1;
      end else if (pin_q[i] == line_filt[i]) begin
        gl_cnt[i] <= '0;
      end else if (gl_cnt[i] == GLITCH_LAST) begin
        gl_cnt[i]    <= '0;
        line_filt[i] <= pin_q[i];
      end else begin
        gl_cnt[i] <= gl_cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge sample_clk) begin
    if (link_rst) begin
      line_prev <= 2'h3;
    end else begin
      line_prev <= line_filt;
    end
  end

  // Both lines see the same delay, so their ordering survives filtering
  assign scl      = line_filt[0];
  assign sda      = line_filt[1];
  assign scl_rise = scl & ~line_prev[0];
  assign scl_fall = ~scl & line_prev[0];
  assign start_ev = scl & line_prev[0] & line_prev[1] & ~sda;
  assign stop_ev  = scl & line_prev[0] & ~line_prev[1] & sda;

  assign sel_hit = shreg[BYTE_W-1:SEL_CODE_LSB] == SEL_CODE &&
                   shreg[SEL_CODE_LSB-1:STRAP_LSB] == straps_q;
  assign rd_byte = mem[addr];

  // Protocol engine
  always_ff @(posedge sample_clk) begin
    if (link_rst) begin
      state      <= ST_IDLE;
      byte_idx   <= BI_SEL;
      bit_cnt    <= '0;
      shreg      <= '0;
      tx         <= '0;
      rd_mode    <= 1'b0;
      acked      <= 1'b0;
      addr       <= '0;
      wmask      <= '0;
      wr_pending <= 1'b0;
      commit_go  <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
    end else begin
      commit_go <= 1'b0;
      if (start_ev) begin
        sda_oe     <= 1'b0;
        wr_pending <= 1'b0;
        bit_cnt    <= '0;
        byte_idx   <= BI_SEL;
        state      <= write_busy ? ST_IDLE : ST_RECV;
      end else if (stop_ev) begin
        sda_oe     <= 1'b0;
        state      <= ST_IDLE;
        wr_pending <= 1'b0;
        commit_go  <= wr_pending & ~wp_q;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise) begin
              shreg   <= {shreg[BYTE_W-2:0], sda};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              bit_cnt <= '0;
              state   <= ST_ACK;
              sda_oe  <= 1'b1;
              unique case (byte_idx)
                BI_SEL: begin
                  if (sel_hit) begin
                    rd_mode  <= shreg[RW_BIT];
                    byte_idx <= BI_AHI;
                  end else begin
                    state  <= ST_IDLE;
                    sda_oe <= 1'b0;
                  end
                end
                BI_AHI: begin
                  addr[ADDR_W-1:BYTE_W] <= shreg[ADDR_HI_W-1:0];
                  byte_idx              <= BI_ALO;
                end
                BI_ALO: begin
                  addr[BYTE_W-1:0] <= shreg;
                  wmask            <= '0;
                  byte_idx         <= BI_DATA;
                end
                BI_DATA: begin
                  page_buf[addr[PAGE_W-1:0]] <= shreg;
                  wmask[addr[PAGE_W-1:0]]    <= 1'b1;
                  wr_pending                 <= 1'b1;
                  addr[PAGE_W-1:0]           <= addr[PAGE_W-1:0] + 1'b1;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_mode) begin
                tx      <= {rd_byte[BYTE_W-2:0], 1'b0};
                sda_oe  <= ~rd_byte[BYTE_W-1];
                addr    <= addr + 1'b1;
                bit_cnt <= 4'h1;
                state   <= ST_SEND;
              end else begin
                sda_oe <= 1'b0;
                state  <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                sda_oe  <= 1'b0;
                bit_cnt <= '0;
                state   <= ST_MACK;
              end else begin
                sda_oe  <= ~tx[BYTE_W-1];
                tx      <= {tx[BYTE_W-2:0], 1'b0};
                bit_cnt <= bit_cnt + 1'b1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              acked <= ~sda;
            end else if (scl_fall) begin
              if (acked) begin
                // Sequential read rolls over the whole array
                tx      <= {rd_byte[BYTE_W-2:0], 1'b0};
                sda_oe  <= ~rd_byte[BYTE_W-1];
                addr    <= addr + 1'b1;
                bit_cnt <= 4'h1;
                state   <= ST_SEND;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Commit and busy tracking; busy clears only when the timer reports back
  always_ff @(posedge sample_clk) begin
    if (link_rst) begin
      write_busy     <= 1'b0;
      committing     <= 1'b0;
      commit_idx     <= '0;
      done_seen      <= 1'b0;
      wr_bus.req_tgl <= 1'b0;
    end else begin
      if (commit_go) begin
        write_busy     <= 1'b1;
        committing     <= 1'b1;
        commit_idx     <= '0;
        wr_bus.req_tgl <= ~wr_bus.req_tgl;
      end else if (committing) begin
        commit_idx <= commit_idx + 1'b1;
        committing <= ~(&commit_idx);
      end
      if (done_q != done_seen) begin
        done_seen  <= done_q;
        write_busy <= 1'b0;
      end
    end
  end

  // Only bytes received in this sequence are programmed; the rest keep their data
  always_ff @(posedge sample_clk) begin
    if (committing && wmask[commit_idx]) begin
      mem[{addr[ADDR_W-1:PAGE_W], commit_idx}] <= page_buf[commit_idx];
    end
  end
endmodule

/* File: include/twe_pkg.sv */
// Constants and types for the two-wire EEPROM target
package twe_pkg;
  localparam int ADDR_W = 15;
  localparam int DEPTH = 32768;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int BYTE_W = 8;
  localparam int ADDR_HI_W = ADDR_W - BYTE_W;
  localparam int STRAP_W = 3;
  localparam int SEL_CODE_LSB = 4;
  localparam int STRAP_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [3:0] SEL_CODE = 4'hA;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 12;
  localparam int WRITE_TIME_MS = 5;
  localparam int NS_PER_MS = 1000000;
  // Stop detection and both toggle crossings eat into the 5 ms budget
  localparam int WRITE_SYNC_MARGIN = 16;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS - WRITE_SYNC_MARGIN;
  localparam int GLITCH_LV_NS = 100;
  localparam int GLITCH_HV_NS = 50;
  localparam int GLITCH_CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h3,
    ST_SEND = 3'h2,
    ST_MACK = 3'h6
  } twe_state_t;

  typedef enum logic [1:0] {
    BI_SEL  = 2'h0,
    BI_AHI  = 2'h1,
    BI_ALO  = 2'h3,
    BI_DATA = 2'h2
  } twe_byte_t;

  // Least time in sampling cycles, rounded up, never below one
  function automatic int ns_to_link_cycles(input int ns);
    int c;
    c = (ns + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
endpackage

/* File: include/twe_wr_if.sv */
// Handshake carrier between the link side and the write-cycle timer
`timescale 1ns/100ps
interface twe_wr_if;
  logic req_tgl;
  logic done_tgl;
  modport link  (output req_tgl, input done_tgl);
  modport timer (input req_tgl, output done_tgl);
endinterface

/* File: logic/twe_sync.sv */
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
module twe_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;

  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= (s3 & agree) | (q & ~agree);
    end
  end
endmodule

/* File: logic/twe_wr_timer.sv */
// Self-timed programming cycle counter on the system clock
`timescale 1ns/100ps
module twe_wr_timer import twe_pkg::*; #(
  parameter int CYCLES = WRITE_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  twe_wr_if.timer   wr
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic             req_q;
  logic             req_seen;
  logic             running;
  logic [CNT_W-1:0] cnt;

  twe_sync #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (wr.req_tgl),
    .q   (req_q)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_seen    <= 1'b0;
      running     <= 1'b0;
      cnt         <= '0;
      wr.done_tgl <= 1'b0;
    end else if (!running && req_q != req_seen) begin
      req_seen <= req_q;
      running  <= 1'b1;
      cnt      <= '0;
    end else if (running && cnt == CNT_LAST) begin
      running     <= 1'b0;
      wr.done_tgl <= ~wr.done_tgl;
    end else if (running) begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

/* File: sim/twe_chk.sv */
// Concurrent checks on the two-wire EEPROM target pins
`timescale 1ns/100ps
module twe_chk import twe_pkg::*; #(
  parameter int WR_CYCLES = WRITE_CYCLES
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               sample_clk,
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  input wire logic [STRAP_W-1:0] device_select_straps,
  input wire logic               write_protect,
  input wire logic               write_busy
);
  // Sampling runs 12 ns against 40 ns timer cycles, plus sync slack
  localparam int BUSY_MIN = WR_CYCLES * 3;
  localparam int BUSY_MAX = WR_CYCLES * 4 + 40;
  int busy_len;
  default clocking cb @(posedge sample_clk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sample_clk) begin
    if (sys_rst || !write_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  a_out_low: assert property (!sda_out)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data output moved with serial clock high");
  a_oe_scl_high: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("data output released with serial clock high");
  a_oe_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("pull-down shorter than a bit");
  a_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("answer during write cycle");
  a_busy_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write cycle began off a stop");
  a_busy_wp: assert property ($rose(write_busy) |-> !write_protect)
    else $error("write cycle while protected");
  a_busy_max: assert property (busy_len < BUSY_MAX)
    else $error("write cycle too long");
  a_busy_min: assert property ($fell(write_busy) |-> busy_len >= BUSY_MIN)
    else $error("write cycle too short");
  c_write: cover property ($rose(write_busy));
  c_done: cover property ($fell(write_busy));
  c_wp_ack: cover property (write_protect && $rose(sda_oe));
endmodule

/* File: sim/twe_ctl_model.sv */
// Bus controller model: drives the serial clock, pulls the data wire low
`timescale 1ns/100ps
module twe_ctl_model (
  input  wire logic clk,
  input  wire logic sda,
  input  wire logic glitch,
  output logic      scl,
  output logic      pull
);
  initial begin
    scl = 1'h1;
    pull = 1'h0;
  end
  // 13 cycles a half keeps the serial clock just below 1 MHz
  task automatic half();
    repeat (13) @(posedge clk);
  endtask
  // Leading wait so data never moves on a clock edge
  task automatic start();
    repeat (4) @(posedge clk);
    pull <= 1'h0;
    half();
    scl <= 1'h1;
    half();
    pull <= 1'h1;
    half();
    scl <= 1'h0;
  endtask
  task automatic stop();
    repeat (4) @(posedge clk);
    pull <= 1'h1;
    half();
    scl <= 1'h1;
    half();
    pull <= 1'h0;
    half();
  endtask
  // Optional 40 ns clock spike in the low phase
  task automatic bit_x(input logic b, output logic r);
    repeat (4) @(posedge clk);
    pull <= !b;
    repeat (4) @(posedge clk);
    scl <= glitch;
    @(posedge clk);
    scl <= 1'h0;
    repeat (4) @(posedge clk);
    scl <= 1'h1;
    half();
    r = sda;
    scl <= 1'h0;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'h1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'h1, d[i]);
    bit_x(last, r);
  endtask
endmodule

/* File: sim/test_two_wire_eeprom_target.sv */
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/100ps
module test_two_wire_eeprom_target import twe_pkg::*; ;
  localparam int WRC = 400;
  logic               clk = 1'h0;
  logic               sample_clk = 1'h0;
  logic               sys_rst = 1'h1;
  logic [STRAP_W-1:0] straps = 3'h5;
  logic [STRAP_W-1:0] straps_lv = 3'h2;
  logic               wp = 1'h0;
  logic               scl;
  logic               pull;
  logic               glitch = 1'h0;
  logic               sda_out;
  logic               sda_oe;
  logic               busy;
  logic               sda_out_lv;
  logic               sda_oe_lv;
  logic               busy_lv;
  wire                sda = !(sda_oe || sda_oe_lv || pull);
  int                 err_total = 0;
  int                 n_tests = 0;
  always #20 clk = !clk;
  always #6 sample_clk = !sample_clk;
  twe_target #(.WR_CYCLES(WRC)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .sample_clk(sample_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .device_select_straps(straps), .write_protect(wp), .write_busy(busy));
  // Second target on other straps exercises the slower input filter
  twe_target #(.WR_CYCLES(WRC), .LOW_VOLTAGE(1'b1)) dut_lv_u (
    .clk(clk), .sys_rst(sys_rst), .sample_clk(sample_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out_lv), .sda_oe(sda_oe_lv),
    .device_select_straps(straps_lv), .write_protect(wp), .write_busy(busy_lv));
  twe_ctl_model ctl_u (.clk(clk), .sda(sda), .glitch(glitch), .scl(scl), .pull(pull));
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic idle();
    for (int i = 0; i < 2 * WRC && busy !== 1'h0; i++)
      @(posedge clk);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d[$]);
    logic k;
    logic all;
    ctl_u.start();
    ctl_u.put({SEL_CODE, straps, 1'h0}, all);
    ctl_u.put({1'h0, a[14:8]}, k);
    all &= k;
    ctl_u.put(a[7:0], k);
    all &= k;
    foreach (d[i]) begin
      ctl_u.put(d[i], k);
      all &= k;
    end
    ctl_u.stop();
    check("write acks", 8'(all), 8'h01);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
    logic k;
    logic [7:0] d;
    ctl_u.start();
    ctl_u.put({SEL_CODE, straps, 1'h0}, k);
    ctl_u.put({1'h0, a[14:8]}, k);
    ctl_u.put(a[7:0], k);
    ctl_u.start();
    ctl_u.put({SEL_CODE, straps, 1'h1}, k);
    check("read ack", 8'(k), 8'h01);
    foreach (e[i]) begin
      ctl_u.get(i == e.size() - 1, d);
      check("read data", d, e[i]);
    end
    ctl_u.stop();
  endtask
  task automatic t_select();
    logic k;
    for (int s = 0; s < 9; s++) begin
      ctl_u.start();
      ctl_u.put({s == 8 ? 4'h5 : SEL_CODE, s[2:0], 1'h0}, k);
      ctl_u.stop();
      check("select ack", 8'(k), 8'(s < 8 && (s[2:0] == straps || s[2:0] == straps_lv)));
      idle();
    end
    check("data out level", 8'({sda_out, sda_out_lv}), 8'h00);
  endtask
  task automatic t_page();
    logic k;
    glitch <= 1'h1;
    wr(15'h01FE, '{8'hA1, 8'hB2, 8'hC3});
    glitch <= 1'h0;
    check("busy start", 8'(busy), 8'h01);
    check("other busy", 8'(busy_lv), 8'h00);
    ctl_u.start();
    ctl_u.put({SEL_CODE, straps, 1'h0}, k);
    ctl_u.stop();
    check("poll ack", 8'(k), 8'h00);
    idle();
    check("busy end", 8'(busy), 8'h00);
    rd(15'h01FE, '{8'hA1, 8'hB2});
    rd(15'h01C0, '{8'hC3});
  endtask
  task automatic t_protect();
    wp <= 1'h1;
    wr(15'h01C0, '{8'h5A});
    check("protected busy", 8'(busy), 8'h00);
    wp <= 1'h0;
    rd(15'h01C0, '{8'hC3});
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (10) @(posedge clk);
    t_select();
    t_page();
    t_protect();
    test_done();
  end
  // Whole run needs about 10000 cycles; five times that is a hang
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
bind twe_target twe_chk #(.WR_CYCLES(WR_CYCLES)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .sample_clk(sample_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .device_select_straps(device_select_straps),
  .write_protect(write_protect), .write_busy(write_busy));
